// ===== velocity_profile_pkg.sv
// Shared constants, parameter addresses and types of the velocity profile generator
package velocity_profile_pkg;

   // ------------------------------------------------------------------
   // Parameter addresses
   // ------------------------------------------------------------------
   localparam logic [15:0] ADDR_VEL_CEILING = 16'h0612;
   localparam logic [15:0] ADDR_ACCEL_SLOPE = 16'h0614;
   localparam logic [15:0] ADDR_DECEL_SLOPE = 16'h0616;
   localparam logic [15:0] ADDR_JERK_TIME = 16'h061a;
   localparam logic [15:0] ADDR_HALT_METHOD = 16'h062e;
   localparam logic [15:0] ADDR_PROFILE_SWITCH = 16'h0656;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [31:0] RST_VEL_CEILING = 32'h0000_3390;
   localparam logic [31:0] RST_ACCEL_SLOPE = 32'h0000_0258;
   localparam logic [31:0] RST_DECEL_SLOPE = 32'h0000_0258;
   localparam logic [15:0] RST_JERK_TIME = 16'h0000;
   localparam logic [15:0] RST_HALT_METHOD = 16'h0001;
   localparam logic [15:0] RST_PROFILE_SWITCH = 16'h0001;

   // ------------------------------------------------------------------
   // Field encodings and limits
   // ------------------------------------------------------------------
   localparam logic [15:0] PROFILE_OFF = 16'h0000;
   localparam logic [15:0] PROFILE_ON = 16'h0001;
   localparam logic [15:0] HALT_BY_DECEL_RAMP = 16'h0001;
   localparam logic [15:0] HALT_BY_TORQUE_RAMP = 16'h0003;
   localparam logic [15:0] JERK_OFF = 16'h0000;
   localparam logic [15:0] JERK_MAX_MS = 16'h0080;
   localparam logic [31:0] DECEL_MIN_VEL_MODE = 32'h0000_0001;
   localparam logic [31:0] DECEL_MIN_POS_MODES = 32'h0000_0078;
   localparam logic [31:0] VEL_LIMIT_MAX = 32'h7fff_ffff;

   // ------------------------------------------------------------------
   // Timing: one profile update per period
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int UPDATE_PERIOD_NS = 1000000;
   localparam int UPDATE_CYCLES = (UPDATE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_NONE = 3'h0,
      MODE_JOG = 3'h1,
      MODE_PROFILE_POSITION = 3'h2,
      MODE_HOMING = 3'h3,
      MODE_PROFILE_VELOCITY = 3'h4
   } op_mode_t;

   typedef enum logic [1:0] {
      HALT_RUN = 2'h0,
      HALT_STOP_RAMP = 2'h1,
      HALT_STOP_TORQUE = 2'h2,
      HALT_HELD = 2'h3
   } halt_state_t;

endpackage : velocity_profile_pkg

// ===== ramp_if.sv
// Carrier between the profile core and its ramp stepper
interface ramp_if;
   logic signed [31:0] cur;
   logic signed [31:0] tgt;
   logic [31:0] accStep;
   logic [31:0] decStep;
   logic signed [31:0] nxt;
   logic decelerating;

   modport stepper (input cur, tgt, accStep, decStep, output nxt, decelerating);
   modport user (output cur, tgt, accStep, decStep, input nxt, decelerating);
endinterface : ramp_if

// ===== ramp_step.sv
// One linear ramp step from the present velocity toward the target
module ramp_step (
   ramp_if.stepper r
);
   logic signed [32:0] diff;
   logic signed [32:0] step;
   logic awayFromZero;

   // ------------------------------------------------------------------
   // Step selection
   // ------------------------------------------------------------------
   // Same rule mirrored for both signs, so both directions ramp alike
   always_comb begin
      diff = {r.tgt[31], r.tgt} - {r.cur[31], r.cur};
      awayFromZero = (diff > 0 && !r.cur[31]) || (diff < 0 && (r.cur[31] || r.cur == 0));
      step = awayFromZero ? $signed({1'b0, r.accStep}) : $signed({1'b0, r.decStep});
      r.decelerating = !awayFromZero && diff != 0;
      if (diff > step) begin
         r.nxt = 32'(r.cur + step[31:0]);
      end else if (diff < -step) begin
         r.nxt = 32'(r.cur - step[31:0]);
      end else begin
         r.nxt = r.tgt; // Last partial step lands exactly
      end
   end
endmodule : ramp_step

// ===== jerk_filter.sv
// Power-of-two smoothing of the ramp output to soften acceleration changes
module jerk_filter (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic smoothOn,
   input wire logic [3:0] shiftSel,
   input wire logic signed [31:0] velIn,
   output logic signed [31:0] velOut
);
   logic signed [32:0] diff;
   logic signed [32:0] step;

   // Small positive differences step whole, else the output would never settle
   always_comb begin
      diff = {velIn[31], velIn} - {velOut[31], velOut};
      step = diff >>> shiftSel;
      if (step == 0) begin
         step = diff;
      end
   end

   // ------------------------------------------------------------------
   // Filter state
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         velOut <= '0;
      end else if (!smoothOn) begin
         velOut <= velIn;
      end else if (tick) begin
         velOut <= 32'(velOut + step[31:0]);
      end
   end
endmodule : jerk_filter

// ===== velocity_ramp_profile_halt.sv
// Velocity motion profile with ramp limits, jerk smoothing and resumable halt
//
// Behaviour
// - Profile always active in jog, profile position and homing modes.
// - Separate programmable acceleration and deceleration slopes, velocity per update.
// - Profile switch: 0 turns profile off, 1 turns it on.
// - Switch and ceiling writable only with power stage off; switch acts at once.
// - Reference velocity above the ceiling is clamped to it in profile modes.
// - Writing zero to acceleration or deceleration leaves the old value.
// - Ceiling and slopes enter the profile only at the next movement start.
// - Deceleration at least 1 in profile velocity, 120 in positioning modes.
// - Jerk smoothing only in jog, profile position and homing.
// - Jerk 0 off; 1,2,4..128 give that many milliseconds of smoothing.
// - Jerk writable only when mode finished flag is 1; used next movement.
// - Halt interrupts the movement but keeps its target for resuming.
// - Halt comes from a digital input or a fieldbus command.
// - Halt method 1 means deceleration ramp, 3 torque ramp; default 1.
// - Ramp halt uses profile deceleration; torque halt uses halt current limit. With profile off, ramp halt drops velocity to zero at once.
// - Halt method writes refused during a deceleration ramp; else act at once.
// - Linear ramp behaves identically in both directions.
// - Torque halt limit is lowest of halt, motor and power stage peak.
module velocity_ramp_profile_halt
   import velocity_profile_pkg::*;
#(
   parameter int UPDATE_CYCLES_P = velocity_profile_pkg::UPDATE_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire velocity_profile_pkg::op_mode_t opMode,
   input wire logic powerStageEnabled,
   input wire logic modeFinished,
   input wire logic moveStart,
   input wire logic signed [31:0] targetVelocity,
   input wire logic haltPin,
   input wire logic haltInputAssigned,
   input wire logic haltFieldbus,
   input wire logic [15:0] haltCurrentLimit,
   input wire logic [15:0] motorPeakCurrent,
   input wire logic [15:0] powerStagePeakCurrent,
   input wire logic parWrite,
   input wire logic parRead,
   input wire logic [15:0] parAddr,
   input wire logic [31:0] parWdata,
   output logic [31:0] parRdata,
   output logic parAck,
   output logic parReject,
   output logic signed [31:0] velocityRef,
   output logic [15:0] currentLimit,
   output logic haltActive,
   output logic decelActive,
   output logic profileActive
);
   import velocity_profile_pkg::*;

   // ------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------
   if (UPDATE_CYCLES_P < 1) begin : g_bad_update
      $error("UPDATE_CYCLES_P must be at least one");
   end

   // ------------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------------
   // Velocity clamp to the symmetric ceiling
   function automatic logic signed [31:0] clampVel(input logic signed [31:0] v,
                                                   input logic [31:0] lim);
      logic signed [31:0] limS;
      limS = $signed(lim & VEL_LIMIT_MAX);
      if (v > limS) begin
         return limS;
      end else if (v < -limS) begin
         return -limS;
      end
      return v;
   endfunction : clampVel

   function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
      return (a < b) ? a : b;
   endfunction : min16

   // Jerk code to filter shift; only zero and powers of two up to 128 are legal
   function automatic logic jerkLegal(input logic [15:0] j);
      return j == JERK_OFF || (j <= JERK_MAX_MS && (j & (j - 16'h0001)) == 16'h0000);
   endfunction : jerkLegal

   function automatic logic [3:0] jerkShift(input logic [15:0] j);
      logic [3:0] s;
      s = 4'h0;
      for (int i = 0; i < 8; i++) begin
         if (j[i]) begin
            s = 4'(i);
         end
      end
      return s;
   endfunction : jerkShift

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   logic [31:0] ceiling_reg, accel_reg, decel_reg;
   logic [15:0] jerk_reg, haltMethod_reg, switch_reg;
   logic [31:0] actCeiling_reg, actAccel_reg, actDecel_reg;
   logic [15:0] actJerk_reg;
   logic signed [31:0] heldTarget_reg, velocity_reg;
   logic [31:0] tickCnt_reg;
   logic tick_reg;
   logic haltMeta_reg, haltSync_reg;
   halt_state_t haltState_reg, haltState_next;
   logic usesProfile, profileOn, haltReq, writeOk, addrHit;
   logic [31:0] decelFloor, decelEff;
   logic signed [31:0] rampTarget;
   logic [3:0] jerkShiftSel;

   ramp_if ramp ();

   // ------------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------------
   // Positioning style modes force the profile and allow smoothing
   assign usesProfile = opMode == MODE_JOG || opMode == MODE_PROFILE_POSITION ||
                        opMode == MODE_HOMING;
   assign profileOn = usesProfile || switch_reg == PROFILE_ON;
   assign decelFloor = usesProfile ? DECEL_MIN_POS_MODES : DECEL_MIN_VEL_MODE;
   assign decelEff = (actDecel_reg < decelFloor) ? decelFloor : actDecel_reg;

   // ------------------------------------------------------------------
   // Halt request path
   // ------------------------------------------------------------------
   // Pin is asynchronous; only the second stage is looked at
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         haltMeta_reg <= 1'b0;
         haltSync_reg <= 1'b0;
      end else begin
         haltMeta_reg <= haltPin;
         haltSync_reg <= haltMeta_reg;
      end
   end

   assign haltReq = haltFieldbus || (haltInputAssigned && haltSync_reg);

   // Halt sequencing; release from any state resumes the movement
   always_comb begin
      haltState_next = haltState_reg;
      unique case (haltState_reg)
         HALT_RUN: begin
            if (haltReq) begin
               haltState_next = (haltMethod_reg == HALT_BY_TORQUE_RAMP) ?
                                HALT_STOP_TORQUE : HALT_STOP_RAMP;
            end
         end
         HALT_STOP_RAMP, HALT_STOP_TORQUE: begin
            if (!haltReq) begin
               haltState_next = HALT_RUN;
            end else if (velocity_reg == 0) begin
               haltState_next = HALT_HELD;
            end
         end
         HALT_HELD: begin
            if (!haltReq) begin
               haltState_next = HALT_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         haltState_reg <= HALT_RUN;
      end else begin
         haltState_reg <= haltState_next;
      end
   end

   // ------------------------------------------------------------------
   // Update tick
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tickCnt_reg <= '0;
         tick_reg <= 1'b0;
      end else if (tickCnt_reg == 32'(UPDATE_CYCLES_P - 1)) begin
         tickCnt_reg <= '0;
         tick_reg <= 1'b1;
      end else begin
         tickCnt_reg <= tickCnt_reg + 32'h0000_0001;
         tick_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Parameter access
   // ------------------------------------------------------------------
   // Write acceptance per address, including the interlocks
   always_comb begin
      addrHit = 1'b1;
      writeOk = 1'b1;
      unique case (parAddr)
         ADDR_VEL_CEILING: writeOk = !powerStageEnabled && parWdata <= VEL_LIMIT_MAX;
         ADDR_PROFILE_SWITCH: writeOk = !powerStageEnabled && parWdata[31:1] == '0;
         ADDR_ACCEL_SLOPE, ADDR_DECEL_SLOPE: writeOk = parWdata <= VEL_LIMIT_MAX;
         ADDR_JERK_TIME: writeOk = modeFinished && parWdata[31:16] == '0 &&
                                   jerkLegal(parWdata[15:0]);
         ADDR_HALT_METHOD: writeOk = !decelActive && (parWdata == 32'(HALT_BY_DECEL_RAMP) ||
                                     parWdata == 32'(HALT_BY_TORQUE_RAMP));
         default: begin
            addrHit = 1'b0;
            writeOk = 1'b0;
         end
      endcase
   end

   // Stored parameters; a zero slope write is acknowledged but dropped
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ceiling_reg <= RST_VEL_CEILING;
         accel_reg <= RST_ACCEL_SLOPE;
         decel_reg <= RST_DECEL_SLOPE;
         jerk_reg <= RST_JERK_TIME;
         haltMethod_reg <= RST_HALT_METHOD;
         switch_reg <= RST_PROFILE_SWITCH;
      end else if (parWrite && writeOk) begin
         unique case (parAddr)
            ADDR_VEL_CEILING: ceiling_reg <= parWdata;
            ADDR_ACCEL_SLOPE: if (parWdata != '0) accel_reg <= parWdata;
            ADDR_DECEL_SLOPE: if (parWdata != '0) decel_reg <= parWdata;
            ADDR_JERK_TIME: jerk_reg <= parWdata[15:0];
            ADDR_HALT_METHOD: haltMethod_reg <= parWdata[15:0];
            ADDR_PROFILE_SWITCH: switch_reg <= parWdata[15:0];
            default: ;
         endcase
      end
   end

   // Answer one cycle after the request; unknown address refused
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         parRdata <= '0;
         parAck <= 1'b0;
         parReject <= 1'b0;
      end else begin
         parAck <= parWrite || parRead;
         parReject <= (parWrite && !writeOk) || (parRead && !addrHit);
         if (parRead) begin
            unique case (parAddr)
               ADDR_VEL_CEILING: parRdata <= ceiling_reg;
               ADDR_ACCEL_SLOPE: parRdata <= accel_reg;
               ADDR_DECEL_SLOPE: parRdata <= decel_reg;
               ADDR_JERK_TIME: parRdata <= {16'h0000, jerk_reg};
               ADDR_HALT_METHOD: parRdata <= {16'h0000, haltMethod_reg};
               ADDR_PROFILE_SWITCH: parRdata <= {16'h0000, switch_reg};
               default: parRdata <= '0;
            endcase
         end
      end
   end

   // ------------------------------------------------------------------
   // Movement latching
   // ------------------------------------------------------------------
   // values captured at start
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         actCeiling_reg <= RST_VEL_CEILING;
         actAccel_reg <= RST_ACCEL_SLOPE;
         actDecel_reg <= RST_DECEL_SLOPE;
         actJerk_reg <= RST_JERK_TIME;
      end else if (moveStart) begin
         actCeiling_reg <= ceiling_reg;
         actAccel_reg <= accel_reg;
         actDecel_reg <= decel_reg;
         actJerk_reg <= jerk_reg;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         heldTarget_reg <= '0;
      end else if (haltState_reg == HALT_RUN && !haltReq) begin
         heldTarget_reg <= targetVelocity;
      end
   end

   // ------------------------------------------------------------------
   // Ramp generator
   // ------------------------------------------------------------------
   // clamp in profile modes
   always_comb begin
      if (haltState_reg != HALT_RUN) begin
         rampTarget = '0;
      end else if (profileOn) begin
         rampTarget = clampVel(heldTarget_reg, actCeiling_reg);
      end else begin
         rampTarget = heldTarget_reg;
      end
   end

   assign ramp.cur = velocity_reg;
   assign ramp.tgt = rampTarget;
   assign ramp.accStep = actAccel_reg;
   assign ramp.decStep = decelEff;

   ramp_step u_step (
      .r(ramp.stepper)
   );

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         velocity_reg <= '0;
      end else if (haltState_reg == HALT_STOP_TORQUE) begin
         velocity_reg <= '0; // Current limit brakes, no velocity ramp
      end else if (!profileOn) begin
         velocity_reg <= rampTarget;
      end else if (tick_reg) begin
         velocity_reg <= ramp.nxt; // Target is clamped, so a lower ceiling ramps down
      end
   end

   // ------------------------------------------------------------------
   // Jerk smoothing
   // ------------------------------------------------------------------
   // positioning modes only
   assign jerkShiftSel = jerkShift(actJerk_reg);

   jerk_filter u_jerk (
      .sys_clk(sys_clk),
      .rst(rst),
      .tick(tick_reg),
      .smoothOn(usesProfile && actJerk_reg != JERK_OFF),
      .shiftSel(jerkShiftSel),
      .velIn(velocity_reg),
      .velOut(velocityRef)
   );

   // ------------------------------------------------------------------
   // Status and current limit
   // ------------------------------------------------------------------
   // switch acts at once
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         haltActive <= 1'b0;
         decelActive <= 1'b0;
         profileActive <= 1'b0;
         currentLimit <= '0;
      end else begin
         haltActive <= haltState_next != HALT_RUN;
         decelActive <= profileOn && ramp.decelerating;
         profileActive <= profileOn;
         if (haltState_next != HALT_RUN && haltMethod_reg == HALT_BY_TORQUE_RAMP) begin
            currentLimit <= min16(haltCurrentLimit,
                                  min16(motorPeakCurrent, powerStagePeakCurrent));
         end else begin
            currentLimit <= min16(motorPeakCurrent, powerStagePeakCurrent);
         end
      end
   end

endmodule : velocity_ramp_profile_halt

// ===== velocity_ramp_profile_halt_sva.sv
// Port assertions for the velocity profile generator
module velocity_ramp_profile_halt_sva
   import velocity_profile_pkg::*;
(
   input logic sys_clk,
   input logic rst,
   input velocity_profile_pkg::op_mode_t opMode,
   input logic powerStageEnabled,
   input logic modeFinished,
   input logic haltPin,
   input logic haltInputAssigned,
   input logic haltFieldbus,
   input logic parWrite,
   input logic [15:0] parAddr,
   input logic [31:0] parWdata,
   input logic parAck,
   input logic parReject,
   input logic haltActive,
   input logic decelActive,
   input logic profileActive
);
   // ------------------------------
   // Profile activation, write answers and halt entry
   // ------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_mode_on;
      opMode inside {MODE_JOG, MODE_PROFILE_POSITION, MODE_HOMING} |=> profileActive;
   endproperty
   a_mode_on: assert property (p_mode_on) else $error("profile off");
   property p_sw_code;
      parWrite && parAddr == ADDR_PROFILE_SWITCH && parWdata > 32'h1 |=> parReject;
   endproperty
   a_sw_code: assert property (p_sw_code) else $error("switch code");
   property p_ceil_pwr;
      parWrite && parAddr == ADDR_VEL_CEILING && powerStageEnabled |=> parAck && parReject;
   endproperty
   a_ceil_pwr: assert property (p_ceil_pwr) else $error("ceiling write");
   property p_zero_slope;
      parWrite && parAddr == ADDR_ACCEL_SLOPE && parWdata == 32'h0 |=> parAck && !parReject;
   endproperty
   a_zero_slope: assert property (p_zero_slope) else $error("zero slope");
   property p_jerk_code;
      parWrite && parAddr == ADDR_JERK_TIME && !($onehot0(parWdata) && parWdata <= 32'h80)
         |=> parReject;
   endproperty
   a_jerk_code: assert property (p_jerk_code) else $error("jerk code");
   property p_jerk_busy;
      parWrite && parAddr == ADDR_JERK_TIME && !modeFinished |=> parReject;
   endproperty
   a_jerk_busy: assert property (p_jerk_busy) else $error("jerk busy");
   property p_halt_bus;
      haltFieldbus |=> haltActive;
   endproperty
   a_halt_bus: assert property (p_halt_bus) else $error("bus halt");
   property p_halt_pin;
      (haltInputAssigned && haltPin) [*4] |=> haltActive;
   endproperty
   a_halt_pin: assert property (p_halt_pin) else $error("pin halt");
   property p_halt_code;
      parWrite && parAddr == ADDR_HALT_METHOD && !(parWdata inside {32'h1, 32'h3}) |=> parReject;
   endproperty
   a_halt_code: assert property (p_halt_code) else $error("halt code");
   property p_halt_busy;
      parWrite && parAddr == ADDR_HALT_METHOD && decelActive |=> parReject;
   endproperty
   a_halt_busy: assert property (p_halt_busy) else $error("halt busy");
endmodule : velocity_ramp_profile_halt_sva

// ===== halt_input_source.sv
// Controller side digital input that carries the halt button
module halt_input_source (
   input logic sys_clk,
   input logic press,
   output logic haltPin,
   output logic haltInputAssigned
);
   timeunit 1ns;
   timeprecision 1ps;
   // assign before use
   // Button is masked until the halt function sits on the input
   always @(posedge sys_clk) begin
      haltInputAssigned <= #2 1'b1;
      haltPin <= #2 press & haltInputAssigned;
   end
endmodule : halt_input_source

// ===== tb_velocity_ramp_profile_halt.sv
// Self-checking bench for the velocity profile generator
module tb_velocity_ramp_profile_halt;
   import velocity_profile_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic rej; logic rd; logic [31:0] dat;} note_t;
   logic sys_clk, rst, powerStageEnabled, modeFinished, moveStart, haltFieldbus, press;
   logic haltPin, haltInputAssigned, parWrite, parRead, parAck, parReject;
   logic haltActive, decelActive, profileActive;
   op_mode_t opMode;
   logic signed [31:0] targetVelocity, velocityRef;
   logic [15:0] hcl, mpc, psc, currentLimit, parAddr, lim;
   logic [31:0] parWdata, parRdata;
   note_t expQ[$];
   note_t nt;
   int error_cnt = 0, samples_checked = 0, n, k;
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   halt_input_source src (.sys_clk, .press, .haltPin, .haltInputAssigned);
   // Short tick keeps each ramp under a hundred cycles
   velocity_ramp_profile_halt #(.UPDATE_CYCLES_P(4)) dut (.sys_clk, .rst, .opMode,
      .powerStageEnabled, .modeFinished, .moveStart, .targetVelocity, .haltPin,
      .haltInputAssigned, .haltFieldbus, .haltCurrentLimit(hcl), .motorPeakCurrent(mpc),
      .powerStagePeakCurrent(psc), .parWrite, .parRead, .parAddr, .parWdata, .parRdata,
      .parAck, .parReject, .velocityRef, .currentLimit, .haltActive, .decelActive,
      .profileActive);
   // ------------------------------
   // Shared tasks
   // ------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task automatic conclude();
      chk(32'(expQ.size()), 32'h0, "missing ack");
      if (error_cnt == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : conclude
   // One strobe cycle; the answer is noted for the monitor
   task automatic acc(input logic wr, input logic [15:0] a, input logic [31:0] d,
         input logic rej, input logic [31:0] exp);
      @(posedge sys_clk) #2;
      expQ.push_back({rej, ~wr, exp});
      {parWrite, parRead, parAddr, parWdata} = {wr, ~wr, a, d};
      @(posedge sys_clk) #2;
      {parWrite, parRead} = 2'b0;
   endtask : acc
   task automatic pulse();
      moveStart = 1'b1;
      @(posedge sys_clk) #2;
      moveStart = 1'b0;
   endtask : pulse
   // Waits for the velocity to land, checking every change against the slope
   task automatic settle(input logic signed [31:0] exp, input logic signed [31:0] step);
      logic signed [31:0] prev;
      prev = velocityRef;
      for (n = 0; n < 600 && velocityRef !== exp; n++) begin
         @(posedge sys_clk) #2;
         if (velocityRef - prev > step || prev - velocityRef > step)
            chk(velocityRef, prev, "slope");
         prev = velocityRef;
      end
      chk(velocityRef, exp, "settle");
      if (n >= 600) conclude();
   endtask : settle
   always @(negedge sys_clk) begin
      if (parAck === 1'b1 && expQ.size() > 0) begin
         nt = expQ.pop_front();
         chk({31'h0, parReject}, {31'h0, nt.rej}, "reject");
         if (nt.rd && !nt.rej) chk(parRdata, nt.dat, "rdata");
      end
   end
   // ------------------------------
   // Main sequence
   // ------------------------------
   initial begin
      void'($urandom(32'h9e66));
      {rst, powerStageEnabled, modeFinished} = 3'b101;
      opMode = MODE_PROFILE_VELOCITY;
      {moveStart, haltFieldbus, press, parWrite, parRead} = 5'h0;
      {targetVelocity, parAddr, parWdata} = '0;
      hcl = 16'($urandom_range(1, 5000));
      mpc = 16'($urandom_range(1, 5000));
      psc = 16'($urandom_range(1, 5000));
      repeat (3) @(posedge sys_clk);
      #2 rst = 1'b0;
      acc(0, ADDR_VEL_CEILING, 0, 0, RST_VEL_CEILING);
      acc(0, ADDR_ACCEL_SLOPE, 0, 0, RST_ACCEL_SLOPE);
      acc(0, ADDR_DECEL_SLOPE, 0, 0, RST_DECEL_SLOPE);
      acc(0, ADDR_JERK_TIME, 0, 0, {16'h0, RST_JERK_TIME});
      acc(0, ADDR_HALT_METHOD, 0, 0, {16'h0, RST_HALT_METHOD});
      acc(0, ADDR_PROFILE_SWITCH, 0, 0, {16'h0, RST_PROFILE_SWITCH});
      acc(0, 16'h0700, 0, 1, 0);
      acc(1, ADDR_ACCEL_SLOPE, 0, 0, 0);
      acc(0, ADDR_ACCEL_SLOPE, 0, 0, RST_ACCEL_SLOPE);
      acc(1, ADDR_DECEL_SLOPE, 0, 0, 0);
      acc(0, ADDR_DECEL_SLOPE, 0, 0, RST_DECEL_SLOPE);
      powerStageEnabled = 1'b1;
      acc(1, ADDR_VEL_CEILING, $urandom_range(1, 99999), 1, 0);
      acc(1, ADDR_PROFILE_SWITCH, 0, 1, 0);
      powerStageEnabled = 1'b0;
      acc(1, ADDR_PROFILE_SWITCH, 2, 1, 0);
      modeFinished = 1'b0;
      acc(1, ADDR_JERK_TIME, 4, 1, 0);
      modeFinished = 1'b1;
      for (k = 0; k < 9; k++) acc(1, ADDR_JERK_TIME, k == 0 ? 0 : 1 << (k - 1), 0, 0);
      acc(1, ADDR_JERK_TIME, 3, 1, 0);
      acc(1, ADDR_HALT_METHOD, 2, 1, 0);
      targetVelocity = 20000;
      pulse();
      settle(13200, 600);
      acc(1, ADDR_VEL_CEILING, 5000, 0, 0);
      repeat (20) @(posedge sys_clk) #2;
      chk(velocityRef, 13200, "early ceiling");
      pulse();
      settle(5000, 600);
      targetVelocity = -20000;
      settle(-5000, 600);
      haltFieldbus = 1'b1;
      for (n = 0; n < 40 && decelActive !== 1'b1; n++) @(posedge sys_clk) #2;
      chk({31'h0, decelActive}, 32'h1, "no ramp down");
      if (n >= 40) conclude();
      acc(1, ADDR_HALT_METHOD, 3, 1, 0);
      settle(0, 600);
      haltFieldbus = 1'b0;
      settle(-5000, 600);
      acc(1, ADDR_HALT_METHOD, 3, 0, 0);
      press = 1'b1;
      settle(0, 32'h7fff_ffff);
      lim = hcl < mpc ? hcl : mpc;
      lim = lim < psc ? lim : psc;
      chk({16'h0, currentLimit}, {16'h0, lim}, "current");
      press = 1'b0;
      settle(-5000, 600);
      acc(1, ADDR_PROFILE_SWITCH, 0, 0, 0);
      targetVelocity = 20000;
      settle(20000, 32'h7fff_ffff);
      opMode = MODE_JOG;
      repeat (4) @(posedge sys_clk);
      conclude();
   end
endmodule : tb_velocity_ramp_profile_halt
bind velocity_ramp_profile_halt velocity_ramp_profile_halt_sva sva_i (.sys_clk, .rst,
   .opMode, .powerStageEnabled, .modeFinished, .haltPin, .haltInputAssigned, .haltFieldbus,
   .parWrite, .parAddr, .parWdata, .parAck, .parReject, .haltActive, .decelActive,
   .profileActive);
